// ===== pkg/stack_exec_pkg.sv
//==============================================================
// Summary of operation
// RL1: normal-stack pop reads even from pointer-8, odd from pointer-4, lowers pointer by 8.
// RL2: each stack transfer is one 32-bit long-word access.
// RL3: push writes even at active pointer, odd at pointer+4, raises pointer by 8.
// RL4: one or two pushes in a set raise the active pointer once by 8.
// RL5: one or two normal-stack pops in a set lower it once by 8.
// RL6: software pairs one even-group and one odd-group operand per set.
// RL7: popping a full data register sign-extends bits 39..32 and clears its limit tag.
// RL8: popped extensions come from bits 8..0 (even) and 24..16 (odd).
// RL9: pushed extensions go to bits 8..0 (even) and 24..16 (odd).
// RL10: extension pop restores the limit tag; data pop clears it.
// RL11: plain pop picks its pointer and working mode from status bit 18.
// RL12: push picks its pointer from status bit 18 and changes no status bits.
// RL13: pop takes one cycle, plus one when the shadow pointer is stale.
// RL14: decode the even selector, including extension singles and pairs and unused codes.
// RL15: decode the odd selector, including vector base, status, modifier control, loop counts.
// RL16: data and address registers 8..15 are reached only under the high-bank prefix.
// RL17: software pops in the same grouping and form it pushed, extensions last.
// RL18: plain pop uses active pointer minus 8 and minus 4, lowering it once by 8.
// RL19: active pointer is the exception pointer when mode bit is one, else normal.
// RL20: a validity flag tracks the shadow pointer; a stale one stalls the pop once.
package stack_exec_pkg;

	//==============================================================
	// register map (byte offsets)
	localparam logic [11:0] OFS_STATUS_WORD = 12'h000;
	localparam logic [11:0] OFS_NSP = 12'h004;
	localparam logic [11:0] OFS_ESP = 12'h008;
	localparam logic [11:0] OFS_CMD = 12'h00C;
	localparam logic [11:0] OFS_STATE = 12'h010;
	localparam logic [11:0] OFS_EVEN_DATA = 12'h014;
	localparam logic [11:0] OFS_EVEN_EXT = 12'h018;
	localparam logic [11:0] OFS_ODD_DATA = 12'h01C;
	localparam logic [11:0] OFS_ODD_EXT = 12'h020;
	localparam logic [11:0] OFS_EVEN_DEST = 12'h024;
	localparam logic [11:0] OFS_ODD_DEST = 12'h028;
	localparam logic [3:0] MEM_PAGE = 4'h1;

	//==============================================================
	// reset values and field positions
	localparam logic [31:0] STATUS_WORD_RESET = 32'h0000_0000;
	localparam logic [31:0] SP_RESET = 32'h0000_0000;
	localparam int EXP_BIT = 18;
	localparam logic [31:0] SP_STEP = 32'h0000_0008;
	localparam logic [31:0] ODD_SLOT_OFS = 32'h0000_0004;
	localparam int EXT_EVEN_LSB = 0;
	localparam int EXT_ODD_LSB = 16;
	localparam int TAG_POS = 8;
	localparam int SIGN_BIT = 31;

	//==============================================================
	// types
	typedef enum logic [1:0] {OP_PUSH, OP_POP, OP_POPN, OP_RSVD} op_t;

	typedef enum logic [3:0] {
		CLS_UNUSED, CLS_DATA, CLS_ADDR, CLS_BASE, CLS_OFFSET, CLS_MOD,
		CLS_LOOP_START, CLS_LOOP_COUNT, CLS_EXT, CLS_EXT_PAIR,
		CLS_VECTOR_BASE, CLS_STATUS, CLS_MOD_CTRL
	} reg_class_t;

	typedef struct packed {
		logic high_bank;
		logic [4:0] odd_code;
		logic odd_en;
		logic [4:0] even_code;
		logic even_en;
		op_t op;
	} cmd_t;

	typedef struct packed {
		reg_class_t cls;
		logic [3:0] num;
	} dest_t;

	typedef struct packed {
		logic tag;
		logic [7:0] ext;
		logic [31:0] data;
	} operand_t;

	typedef enum logic [1:0] {ST_IDLE, ST_SHADOW, ST_EXEC} exec_state_t;

endpackage : stack_exec_pkg

// ===== design/stack_push_pop_exec.sv
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module stack_push_pop_exec
	import stack_exec_pkg::*;
#(
	parameter int MEM_DEPTH = 64
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic exec_done
);

	localparam int MEM_AW = $clog2(MEM_DEPTH);

	//==============================================================
	// state
	logic [31:0] status_word_reg;
	logic [31:0] nsp_reg;
	logic [31:0] esp_reg;
	cmd_t cmd_reg;
	exec_state_t state_reg;
	logic shadow_valid_reg;
	logic bad_code_reg;
	logic stalled_reg;
	operand_t even_op_reg;
	operand_t odd_op_reg;
	dest_t even_dest_reg;
	dest_t odd_dest_reg;
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic exec_done_reg;
	logic [31:0] stack_mem [MEM_DEPTH];

	//==============================================================
	// selector decode
	function automatic dest_t decode_slot(input logic [4:0] c, input logic odd, input logic hb);
		dest_t d;
		d.cls = CLS_UNUSED;
		d.num = {hb, c[3], c[2], odd};
		case (c[1:0])
			2'h0: begin
				d.cls = c[4] ? CLS_ADDR : CLS_DATA;
			end
			2'h1: begin
				d.num = {1'b0, c[3] & ~c[4], c[2], odd};
				if (!c[4]) begin
					d.cls = CLS_BASE;
				end else if (c[3]) begin
					d.cls = CLS_MOD;
				end else begin
					d.cls = CLS_OFFSET;
				end
			end
			2'h2: begin
				d.num = {2'h0, c[3], c[2]};
				if (c[4]) begin
					d.cls = odd ? CLS_LOOP_COUNT : CLS_LOOP_START;
				end else if (odd) begin
					d.num = 4'h0;
					case (c[3:2])
						2'h0: d.cls = CLS_VECTOR_BASE;
						2'h2: d.cls = CLS_STATUS;
						2'h3: d.cls = CLS_MOD_CTRL;
						default: d.cls = CLS_UNUSED;
					endcase
				end
			end
			default: begin
				if (!c[4]) begin
					d.cls = CLS_EXT;
				end else if (!odd) begin
					d.cls = CLS_EXT_PAIR;
				end
			end
		endcase
		return d;
	endfunction : decode_slot

	//==============================================================
	// decode and addressing
	// RL14 even decode
	wire dest_t even_dest = decode_slot(cmd_reg.even_code, 1'b0, cmd_reg.high_bank);
	// RL15 odd decode, RL16 high bank
	wire dest_t odd_dest = decode_slot(cmd_reg.odd_code, 1'b1, cmd_reg.high_bank);
	wire logic even_bad = cmd_reg.even_en && (even_dest.cls == CLS_UNUSED);
	wire logic odd_bad = cmd_reg.odd_en && (odd_dest.cls == CLS_UNUSED);
	wire logic set_bad = even_bad || odd_bad || (cmd_reg.op == OP_RSVD);
	wire logic any_slot = cmd_reg.even_en || cmd_reg.odd_en;
	wire logic is_push = (cmd_reg.op == OP_PUSH);
	wire logic is_popn = (cmd_reg.op == OP_POPN);
	wire logic exp_mode = status_word_reg[EXP_BIT];
	// RL19 active pointer select; RL11 RL12 mode bit steers it
	wire logic use_esp = exp_mode && !is_popn;
	// RL1 normal-stack pop ignores the mode bit
	wire logic [31:0] base_sp = use_esp ? esp_reg : nsp_reg;
	// RL3 push slots at pointer and pointer+4
	wire logic [31:0] even_addr = is_push ? base_sp : base_sp - SP_STEP;
	// RL18 pop slots at pointer-8 and pointer-4
	wire logic [31:0] odd_addr = is_push ? base_sp + ODD_SLOT_OFS : base_sp - ODD_SLOT_OFS;
	wire logic [MEM_AW-1:0] even_idx = even_addr[MEM_AW+1:2];
	wire logic [MEM_AW-1:0] odd_idx = odd_addr[MEM_AW+1:2];
	// RL4 RL5 one step per execution set
	wire logic [31:0] sp_next = is_push ? base_sp + SP_STEP : base_sp - SP_STEP;

	//==============================================================
	// push word packing
	wire logic [8:0] even_ext_field = {even_op_reg.tag, even_op_reg.ext};
	wire logic [8:0] odd_ext_field = {odd_op_reg.tag, odd_op_reg.ext};
	wire logic [31:0] even_ext_word = 32'(even_ext_field) << EXT_EVEN_LSB;
	wire logic [31:0] odd_ext_word = 32'(odd_ext_field) << EXT_ODD_LSB;
	// RL9 extension placement in the stored word
	wire logic [31:0] push_even_word = (even_dest.cls == CLS_EXT) ? even_ext_word :
		(even_dest.cls == CLS_EXT_PAIR) ? (even_ext_word | odd_ext_word) : even_op_reg.data;
	wire logic [31:0] push_odd_word = (odd_dest.cls == CLS_EXT) ? odd_ext_word :
		(odd_dest.cls == CLS_STATUS) ? status_word_reg : odd_op_reg.data;

	//==============================================================
	// pop word unpacking
	// RL2 one long word per slot
	wire logic [31:0] rd_even = stack_mem[even_idx];
	wire logic [31:0] rd_odd = stack_mem[odd_idx];
	wire logic [8:0] rd_even_lo = rd_even[EXT_EVEN_LSB +: 9];
	wire logic [8:0] rd_even_hi = rd_even[EXT_ODD_LSB +: 9];
	wire logic [8:0] rd_odd_hi = rd_odd[EXT_ODD_LSB +: 9];

	function automatic operand_t pop_value(input reg_class_t cls, input logic [31:0] w,
		input logic [8:0] field, input operand_t old);
		operand_t v;
		v = old;
		case (cls)
			// RL8 RL10 extension and tag restored from memory
			CLS_EXT, CLS_EXT_PAIR: begin
				v.tag = field[TAG_POS];
				v.ext = field[7:0];
			end
			// RL7 RL10 sign extension, tag cleared
			CLS_DATA: begin
				v.data = w;
				v.ext = {8{w[SIGN_BIT]}};
				v.tag = 1'b0;
			end
			default: begin
				v.data = w;
			end
		endcase
		return v;
	endfunction : pop_value

	wire operand_t pop_even = pop_value(even_dest.cls, rd_even, rd_even_lo, even_op_reg);
	wire operand_t pair_odd = pop_value(CLS_EXT, rd_even, rd_even_hi, odd_op_reg);
	wire operand_t pop_odd = pop_value(odd_dest.cls, rd_odd, rd_odd_hi, odd_op_reg);

	//==============================================================
	// APB decode
	wire logic setup = psel && !penable;
	wire logic access = psel && penable && pready_reg;
	wire logic busy = (state_reg != ST_IDLE);
	wire logic mem_hit = (paddr[11:8] == MEM_PAGE) && ({1'b0, paddr[7:2]} < 7'(MEM_DEPTH));
	wire logic reg_hit = (paddr[11:8] == 4'h0) && (paddr[7:0] <= OFS_ODD_DEST[7:0]) && (paddr[1:0] == 2'h0);
	wire logic ro_hit = (paddr == OFS_STATE) || (paddr == OFS_EVEN_DEST) || (paddr == OFS_ODD_DEST);
	// writes while a set executes are refused so the two writers never collide
	wire logic wr_refused = pwrite && (busy || ro_hit);
	wire logic addr_err = !(mem_hit || reg_hit) || wr_refused;
	wire logic wr_ok = access && pwrite && !pslverr_reg;
	wire logic wr_sr = wr_ok && (paddr == OFS_STATUS_WORD);
	wire logic wr_nsp = wr_ok && (paddr == OFS_NSP);
	wire logic wr_esp = wr_ok && (paddr == OFS_ESP);
	wire logic wr_cmd = wr_ok && (paddr == OFS_CMD);
	wire logic wr_mem = wr_ok && mem_hit;
	wire logic [31:0] state_word = {28'h0, stalled_reg, shadow_valid_reg, bad_code_reg, busy};

	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (mem_hit) begin
			rd_mux = stack_mem[paddr[MEM_AW+1:2]];
		end else begin
			case (paddr)
				OFS_STATUS_WORD: rd_mux = status_word_reg;
				OFS_NSP: rd_mux = nsp_reg;
				OFS_ESP: rd_mux = esp_reg;
				OFS_CMD: rd_mux = 32'(cmd_reg);
				OFS_STATE: rd_mux = state_word;
				OFS_EVEN_DATA: rd_mux = even_op_reg.data;
				OFS_EVEN_EXT: rd_mux = 32'(even_ext_field);
				OFS_ODD_DATA: rd_mux = odd_op_reg.data;
				OFS_ODD_EXT: rd_mux = 32'(odd_ext_field);
				OFS_EVEN_DEST: rd_mux = 32'(even_dest_reg);
				OFS_ODD_DEST: rd_mux = 32'(odd_dest_reg);
				default: rd_mux = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			prdata_reg <= 32'h0000_0000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg <= setup;
			if (setup) begin
				prdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
				pslverr_reg <= addr_err;
			end
		end
	end

	//==============================================================
	// execution sequencer
	wire logic stale = !shadow_valid_reg && (cmd_reg.op == OP_POP || is_popn);
	wire logic do_exec = ((state_reg == ST_EXEC && !stale) || state_reg == ST_SHADOW) && !set_bad && any_slot;
	wire logic pop_exec = do_exec && !is_push;

	exec_state_t state_next;
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (wr_cmd) begin
					state_next = ST_EXEC;
				end
			end
			ST_SHADOW: begin
				state_next = ST_IDLE;
			end
			ST_EXEC: begin
				// RL13 RL20 stale shadow costs one extra cycle
				state_next = (stale && !set_bad) ? ST_SHADOW : ST_IDLE;
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= ST_IDLE;
			cmd_reg <= '0;
			exec_done_reg <= 1'b0;
			bad_code_reg <= 1'b0;
			stalled_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			exec_done_reg <= (state_reg != ST_IDLE) && (state_next == ST_IDLE);
			if (wr_cmd) begin
				cmd_reg <= cmd_t'(pwdata[$bits(cmd_t)-1:0]);
				stalled_reg <= 1'b0;
			end
			if (state_reg == ST_SHADOW) begin
				stalled_reg <= 1'b1;
			end
			if (state_reg != ST_IDLE && state_next == ST_IDLE) begin
				bad_code_reg <= set_bad;
			end
		end
	end

	//==============================================================
	// stack pointers, status word, shadow flag
	wire logic sr_from_pop = pop_exec && cmd_reg.odd_en && (odd_dest.cls == CLS_STATUS);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			status_word_reg <= STATUS_WORD_RESET;
			nsp_reg <= SP_RESET;
			esp_reg <= SP_RESET;
			shadow_valid_reg <= 1'b0;
		end else begin
			// RL12 pushes never touch the status word
			if (wr_sr) begin
				status_word_reg <= pwdata;
			end else if (sr_from_pop) begin
				status_word_reg <= rd_odd;
			end
			if (wr_nsp) begin
				nsp_reg <= pwdata;
			end else if (do_exec && !use_esp) begin
				// RL1 RL5 normal pointer moves once per set
				nsp_reg <= sp_next;
			end
			if (wr_esp) begin
				esp_reg <= pwdata;
			end else if (do_exec && use_esp) begin
				// RL4 RL18 active pointer moves once per set
				esp_reg <= sp_next;
			end
			// RL20 a pointer or status word write, or a status pop, leaves the shadow copy stale
			if (wr_sr || wr_nsp || wr_esp || sr_from_pop) begin
				shadow_valid_reg <= 1'b0;
			end else if (state_reg == ST_SHADOW) begin
				shadow_valid_reg <= 1'b1;
			end
		end
	end

	//==============================================================
	// operand registers and decoded destinations
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			even_op_reg <= '0;
			odd_op_reg <= '0;
			even_dest_reg <= '0;
			odd_dest_reg <= '0;
		end else begin
			if (wr_ok && paddr == OFS_EVEN_DATA) begin
				even_op_reg.data <= pwdata;
			end
			if (wr_ok && paddr == OFS_EVEN_EXT) begin
				{even_op_reg.tag, even_op_reg.ext} <= pwdata[8:0];
			end
			if (wr_ok && paddr == OFS_ODD_DATA) begin
				odd_op_reg.data <= pwdata;
			end
			if (wr_ok && paddr == OFS_ODD_EXT) begin
				{odd_op_reg.tag, odd_op_reg.ext} <= pwdata[8:0];
			end
			if (state_reg != ST_IDLE && state_next == ST_IDLE) begin
				even_dest_reg <= cmd_reg.even_en ? even_dest : '0;
				odd_dest_reg <= cmd_reg.odd_en ? odd_dest : '0;
			end
			if (pop_exec && cmd_reg.even_en) begin
				even_op_reg <= pop_even;
			end
			// the odd slot outranks an extension pair's odd half
			if (pop_exec && cmd_reg.odd_en) begin
				odd_op_reg <= pop_odd;
			end else if (pop_exec && cmd_reg.even_en && even_dest.cls == CLS_EXT_PAIR) begin
				// RL8 pair's odd half from bits 24..16
				odd_op_reg <= pair_odd;
			end
		end
	end

	//==============================================================
	// stack memory
	always_ff @(posedge clk) begin
		if (wr_mem) begin
			stack_mem[paddr[MEM_AW+1:2]] <= pwdata;
		end
		// RL2 RL3 whole-word writes into each enabled slot
		if (do_exec && is_push && cmd_reg.even_en) begin
			stack_mem[even_idx] <= push_even_word;
		end
		if (do_exec && is_push && cmd_reg.odd_en) begin
			stack_mem[odd_idx] <= push_odd_word;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign exec_done = exec_done_reg;

endmodule : stack_push_pop_exec
`default_nettype wire

// ===== bench/stack_exec_sva.sv
`timescale 1ns/10ps
`default_nettype none
module stack_exec_sva
	import stack_exec_pkg::*;
#(
	parameter int MEM_DEPTH = 64
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic exec_done
);
	//==============================================================
	// request decode
	wire logic setup = psel && !penable;
	wire logic cmd_any = psel && penable && pready && pwrite && !pslverr && paddr == OFS_CMD;
	// a set with no slot enabled need not report completion
	wire logic cmd_go = cmd_any && (pwdata[2] || pwdata[8]);

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	//==============================================================
	// properties
	a_ready_setup: assert property (setup |=> pready)
		else $error("no answer after setup");
	a_ready_single: assert property (pready |=> !pready)
		else $error("answer held too long");
	a_set_done: assert property (cmd_go |-> ##[2:3] exec_done)
		else $error("set did not finish in time");
	a_done_pulse: assert property (exec_done |=> !exec_done)
		else $error("completion longer than one cycle");
	a_done_cause: assert property (exec_done |-> $past(cmd_any, 2) || $past(cmd_any, 3))
		else $error("completion without a set");
	a_ro_state: assert property (setup && pwrite && paddr == OFS_STATE |=> pslverr)
		else $error("write to state accepted");
	a_map_nsp: assert property (setup && !pwrite && paddr == OFS_NSP |=> !pslverr)
		else $error("pointer read refused");
	a_unmapped_err: assert property (setup && paddr == 12'h02C |=> pslverr)
		else $error("unmapped access accepted");
	a_wr_zero_data: assert property (pready && pwrite |-> prdata == 32'h0000_0000)
		else $error("read data on a write");
endmodule : stack_exec_sva
bind stack_push_pop_exec stack_exec_sva #(.MEM_DEPTH(MEM_DEPTH)) i_sva (.clk, .resetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .exec_done);
`default_nettype wire

// ===== bench/stack_ref.sv
`timescale 1ns/10ps
`default_nettype none
module stack_ref #(
	parameter int DEPTH = 64
);
	//==============================================================
	// stack image addressing
	// one word per slot
	function automatic logic [11:0] slot(input logic [31:0] a);
		return 12'h100 + 12'((a >> 2) % DEPTH) * 12'h004;
	endfunction : slot
endmodule : stack_ref
`default_nettype wire

// ===== bench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import stack_exec_pkg::*;
	typedef struct packed {logic chk; logic err; logic [31:0] mask; logic [31:0] val;} note_t;
	//==============================================================
	// signals and tables
	logic clk = 1'b0;
	logic resetn, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q, r0, r1;
	logic pready, pslverr, exec_done;
	int err_total, compares, n, k, i, done_cnt, done_mark;
	note_t notes[$], note;
	logic [4:0] odd_codes [7] = '{5'h02, 5'h0A, 5'h0E, 5'h12, 5'h16, 5'h1A, 5'h1E};
	logic [7:0] odd_dests [7] = '{8'hA0, 8'hB0, 8'hC0, 8'h70, 8'h71, 8'h72, 8'h73};
	logic [5:0] even_codes [8] = '{6'h12, 6'h1E, 6'h1D, 6'h11, 6'h01, 6'h10, 6'h20, 6'h34};
	logic [7:0] even_dests [8] = '{8'h60, 8'h63, 8'h52, 8'h40, 8'h30, 8'h20, 8'h18, 8'h2A};
	logic [4:0] unused_codes [4] = '{5'h02, 5'h06, 5'h0A, 5'h0E};

	always #25 clk = ~clk;

	stack_push_pop_exec #(.MEM_DEPTH(64)) i_dut (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .exec_done);
	stack_ref #(.DEPTH(64)) i_ref ();

	//==============================================================
	// tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task end_sim;
		$display("compares %0d errors %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim

	// one idle cycle between transfers keeps each signal to one assignment per step
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic c, input logic e,
		input logic [31:0] m, input logic [31:0] v);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		notes.push_back({c, e, m, v});
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			err_total++;
			end_sim();
		end
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	task wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, 1'b1, 1'b0, 32'hFFFF_FFFF, 32'h0);
	endtask : wr

	task rd(input logic [11:0] a, input logic [31:0] v, input logic [31:0] m = 32'hFFFF_FFFF);
		xfer(1'b0, a, 32'h0, 1'b1, 1'b0, m, v);
	endtask : rd

	task run(input logic [31:0] c);
		done_mark = done_cnt;
		wr(OFS_CMD, c);
		k = 0;
		do begin
			xfer(1'b0, OFS_STATE, 32'h0, 1'b0, 1'b0, 32'h0, 32'h0);
			k++;
		end while (q[0] !== 1'b0 && k < 16);
		if (q[0] !== 1'b0) begin
			err_total++;
			end_sim();
		end
		check(32'(done_cnt - done_mark), 32'h0000_0001, "exec_done");
	endtask : run

	function automatic logic [31:0] mk(input op_t op, input logic [4:0] ec, input logic [4:0] oc,
		input logic ee, input logic oe, input logic hb);
		cmd_t c;
		c = '{hb, oc, oe, ec, ee, op};
		return {17'h0, c};
	endfunction : mk

	//==============================================================
	// result watcher
	always @(posedge clk) begin
		if (exec_done === 1'b1) begin
			done_cnt++;
		end
		if (psel && penable && pready === 1'b1 && notes.size() > 0) begin
			note = notes.pop_front();
			if (note.chk) begin
				check({31'h0, pslverr}, {31'h0, note.err}, "pslverr");
				check(prdata & note.mask, note.val, "prdata");
			end
		end
	end

	initial begin
		#2000000;
		err_total++;
		end_sim();
	end

	//==============================================================
	// sequence
	initial begin
		void'($urandom(81));
		resetn <= 1'b0;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 12'h000;
		pwdata <= 32'h0000_0000;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		rd(OFS_STATUS_WORD, 32'h0);
		rd(OFS_NSP, 32'h0);
		rd(OFS_STATE, 32'h0);
		r0 = $urandom | 32'h8000_0000;
		r1 = $urandom & 32'h7FFF_FFFF;
		wr(OFS_NSP, 32'h20);
		wr(OFS_ESP, 32'h40);
		wr(OFS_EVEN_DATA, r0);
		wr(OFS_ODD_DATA, r1);
		run(mk(OP_PUSH, 5'h00, 5'h00, 1'b1, 1'b1, 1'b0));
		rd(OFS_NSP, 32'h28);
		rd(i_ref.slot(32'h20), r0);
		rd(i_ref.slot(32'h24), r1);
		rd(OFS_STATUS_WORD, 32'h0);
		rd(OFS_EVEN_DEST, 32'h10);
		rd(OFS_ODD_DEST, 32'h11);
		wr(OFS_STATUS_WORD, 32'h0004_0000);
		run(mk(OP_PUSH, 5'h04, 5'h00, 1'b1, 1'b0, 1'b0));
		rd(OFS_ESP, 32'h48);
		rd(OFS_NSP, 32'h28);
		rd(i_ref.slot(32'h40), r0);
		rd(OFS_STATUS_WORD, 32'h0004_0000);
		wr(i_ref.slot(32'h44), r1);
		run(mk(OP_POP, 5'h04, 5'h04, 1'b1, 1'b1, 1'b0));
		rd(OFS_STATE, 32'hC);
		rd(OFS_ESP, 32'h40);
		rd(OFS_EVEN_DATA, r0);
		rd(OFS_EVEN_EXT, 32'hFF);
		rd(OFS_ODD_DATA, r1);
		rd(OFS_ODD_EXT, 32'h0);
		wr(OFS_EVEN_DATA, 32'h0);
		run(mk(OP_POPN, 5'h00, 5'h00, 1'b1, 1'b0, 1'b0));
		rd(OFS_STATE, 32'h4);
		rd(OFS_NSP, 32'h20);
		rd(OFS_ESP, 32'h40);
		rd(OFS_EVEN_DATA, r0);
		wr(i_ref.slot(32'h18), 32'h00C3_01A5);
		wr(i_ref.slot(32'h1C), 32'h015A_0000);
		run(mk(OP_POPN, 5'h03, 5'h03, 1'b1, 1'b1, 1'b0));
		rd(OFS_EVEN_EXT, 32'h1A5);
		rd(OFS_ODD_EXT, 32'h15A);
		wr(i_ref.slot(32'h10), 32'h00C3_01A5);
		run(mk(OP_POPN, 5'h13, 5'h00, 1'b1, 1'b0, 1'b0));
		rd(OFS_EVEN_EXT, 32'h1A5);
		rd(OFS_ODD_EXT, 32'h0C3);
		rd(OFS_EVEN_DEST, 32'h90);
		run(mk(OP_PUSH, 5'h03, 5'h03, 1'b1, 1'b1, 1'b0));
		rd(i_ref.slot(32'h40), 32'h1A5, 32'h1FF);
		rd(i_ref.slot(32'h44), 32'h00C3_0000, 32'h01FF_0000);
		for (i = 0; i < 7; i++) begin
			run(mk(OP_PUSH, 5'h00, odd_codes[i], 1'b0, 1'b1, 1'b0));
			rd(OFS_ODD_DEST, {24'h0, odd_dests[i]});
		end
		for (i = 0; i < 8; i++) begin
			run(mk(OP_PUSH, even_codes[i][4:0], 5'h00, 1'b1, 1'b0, even_codes[i][5]));
			rd(OFS_EVEN_DEST, {24'h0, even_dests[i]});
		end
		rd(OFS_ESP, 32'hC0);
		for (i = 0; i < 4; i++) begin
			run(mk(OP_PUSH, unused_codes[i], 5'h00, 1'b1, 1'b0, 1'b0));
			rd(OFS_STATE, 32'h2, 32'h2);
		end
		run(mk(OP_PUSH, 5'h00, 5'h13, 1'b0, 1'b1, 1'b0));
		rd(OFS_STATE, 32'h2, 32'h2);
		run(mk(OP_RSVD, 5'h00, 5'h00, 1'b1, 1'b0, 1'b0));
		rd(OFS_STATE, 32'h2, 32'h2);
		rd(OFS_ESP, 32'hC0);
		xfer(1'b0, 12'h02C, 32'h0, 1'b1, 1'b1, 32'h0, 32'h0);
		xfer(1'b1, OFS_STATE, 32'h1, 1'b1, 1'b1, 32'h0, 32'h0);
		end_sim();
	end
endmodule : tb_top
`default_nettype wire
